// >>> csv_params.svh
// constants for the comparator sync and reference control block
`ifndef CSV_PARAMS_SVH
`define CSV_PARAMS_SVH

// ****************************************
// bus layout
// ****************************************
`define CSV_ADR_W          4
`define CSV_DAT_W          32
`define CSV_REG_W          8
`define CSV_SEL_W          4
`define CSV_ADDR_GATE_SYNC 4'h0
`define CSV_ADDR_REF_LEVEL 4'h4
`define CSV_SEL_LOW_LANE   0

// ****************************************
// gate sync control fields
// ****************************************
`define CSV_GS_SYNC_BIT    0
`define CSV_GS_SEL_BIT     1
`define CSV_GS_RESET       8'h02
`define CSV_GS_WMASK       8'h03

// ****************************************
// reference control fields
// ****************************************
`define CSV_RL_EN_BIT      7
`define CSV_RL_RANGE_BIT   5
`define CSV_RL_LVL_MSB     3
`define CSV_RL_LVL_LSB     0
`define CSV_RL_RESET       8'h00
`define CSV_RL_WMASK       8'hAF

// ****************************************
// reference level in 96ths of supply
// ****************************************
`define CSV_LVL_W          4
`define CSV_REF_W          7
`define CSV_REF_HI_BASE    7'h18
`define CSV_REF_HI_STEP    7'h03
`define CSV_REF_LO_STEP    7'h04
`define CSV_REF_GND        7'h00

`endif

// >>> csv_pkg.sv
// types shared by the comparator sync and reference control block
package csv_pkg;

  typedef logic [7:0] csv_byte_t;

  typedef enum logic {
    CSV_BUS_IDLE,
    CSV_BUS_ACK
  } csv_bus_state_e;

endpackage : csv_pkg

// >>> csv_latch_if.sv
// signals between the register block and the comparator latch
`timescale 1ns/100ps

interface csv_latch_if;
  logic sync_en;
  logic presc_used;
  logic raw_clk_lvl;
  logic presc_clk_lvl;
  logic cmp_lvl;
  logic cmp_latched;

  modport ctrl  (output sync_en, presc_used, raw_clk_lvl, presc_clk_lvl, cmp_lvl, input cmp_latched);
  modport latch (input sync_en, presc_used, raw_clk_lvl, presc_clk_lvl, cmp_lvl, output cmp_latched);
endinterface : csv_latch_if

// >>> csv_in_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps

module csv_in_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // pin side
  input  wire logic async_i,
  // filtered level
  output logic      level_o
);

  logic s1_reg, s2_reg, s3_reg, lvl_reg;
  logic lvl_next;

  // a change counts only when the last two stages agree
  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg  <= async_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_o = lvl_reg;

endmodule : csv_in_sync

// >>> csv_cmp_latch.sv
// comparator latch taken on the falling edge of the timer clock
`timescale 1ns/100ps

module csv_cmp_latch (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // control and levels
  csv_latch_if.latch lif
);

  logic tclk_prev_reg, latched_reg;
  logic tclk_sel, tclk_fall, latched_next;

  always_comb begin
    // prescaled clock replaces the raw one when a prescaler is in use
    tclk_sel     = lif.presc_used ? lif.presc_clk_lvl : lif.raw_clk_lvl; // [R2]
    tclk_fall    = tclk_prev_reg & ~tclk_sel;
    latched_next = latched_reg;
    if (lif.sync_en && tclk_fall) begin
      latched_next = lif.cmp_lvl; // [R1]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tclk_prev_reg <= 1'b0;
      latched_reg   <= 1'b0;
    end else begin
      tclk_prev_reg <= tclk_sel;
      latched_reg   <= latched_next;
    end
  end

  assign lif.cmp_latched = latched_reg;

endmodule : csv_cmp_latch

// >>> comparator_sync_vref_ctrl.sv
// register bank for comparator-to-timer sync, gate select and reference control
//
// What this block does
// [R1] With sync on, the second comparator output is latched at each falling timer clock edge and sent on.
// [R2] With a prescaler in use, the latch follows the prescaled timer clock instead of the raw one.
// [R3] The timer counts on the rising clock edge so it never samples the latch as it changes.
// [R4] With sync off, the comparator output goes to the timer unlatched and asynchronous.
// [R5] Gate select bit 1 picks the external gate pin when 1 and the comparator output when 0.
// [R6] Sync enable sits at bit 0 of the gate sync register and is read and written by software.
// [R7] Bits 7 to 2 of the gate sync register ignore writes and read as zero.
// [R8] Reference enable at bit 7 powers the cell when 1, and when 0 powers it down with output at ground.
// [R9] The reference control works regardless of the comparator mode settings.
// [R10] Range select at bit 5 chooses the low range when 1 and the high range when 0.
// [R11] Level code in bits 3 to 0 picks one of 16 levels, 0 to 15.
// [R12] Output is code/24 of supply in low range, and supply/4 plus code/32 of supply in high range.
// [R13] Enable 0, range 1, code 0000 gives a ground reference drawing no reference current.
// [R14] Bits 6 and 4 of the reference register ignore writes and read as zero.
// [R15] Reset returns both control registers to their reset values.
// [R16] Gating by the comparator acts only while the timer runs with gating enabled.
// [R17] Enable, range and level code are static outputs updated with the register write.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "csv_params.svh"

module comparator_sync_vref_ctrl (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`CSV_ADR_W-1:0]  wb_adr_i,
  input  wire logic [`CSV_SEL_W-1:0]  wb_sel_i,
  input  wire logic [`CSV_DAT_W-1:0]  wb_dat_i,
  output logic      [`CSV_DAT_W-1:0]  wb_dat_o,
  output logic                        wb_ack_o,
  // gated timer side
  input  wire logic                   timer_clk_src_i,
  input  wire logic                   timer_presc_clk_i,
  input  wire logic                   timer_presc_used_i,
  input  wire logic                   second_comparator_i,
  input  wire logic                   external_gate_pin_i,
  output logic                        comparator_to_timer_o,
  output logic                        timer_gate_o,
  output logic                        sync_to_timer_enable_o,
  output logic                        gate_source_select_o,
  // reference cell side
  output logic                        ref_enable_o,
  output logic                        ref_range_select_o,
  output logic      [`CSV_LVL_W-1:0]  ref_level_code_o,
  output logic      [`CSV_REF_W-1:0]  internal_ref_output_o
);

  // ****************************************
  // reference level arithmetic
  // ****************************************
  // level in 96ths of supply: 96 is the least common multiple of 24, 32 and 4
  function automatic logic [`CSV_REF_W-1:0] csv_ref_96ths(
    input logic                  en,
    input logic                  low_range,
    input logic [`CSV_LVL_W-1:0] code
  );
    logic [`CSV_REF_W-1:0] code_w;
    code_w = {3'h0, code};
    if (!en) begin
      csv_ref_96ths = `CSV_REF_GND; // [R8] [R13]
    end else if (low_range) begin
      csv_ref_96ths = 7'(code_w * `CSV_REF_LO_STEP); // [R12]
    end else begin
      csv_ref_96ths = 7'(`CSV_REF_HI_BASE + code_w * `CSV_REF_HI_STEP); // [R12]
    end
  endfunction : csv_ref_96ths

  // ****************************************
  // bus slave and registers
  // ****************************************
  csv_pkg::csv_bus_state_e bus_state_reg, bus_state_next;
  csv_pkg::csv_byte_t      gate_sync_reg, gate_sync_next;
  csv_pkg::csv_byte_t      ref_level_reg, ref_level_next;
  logic [`CSV_DAT_W-1:0]   rdata_reg, rdata_next;
  logic                    req;
  logic                    lane_on;

  assign req     = wb_cyc_i & wb_stb_i;
  assign lane_on = wb_sel_i[`CSV_SEL_LOW_LANE];

  // one wait state: ack rises the cycle after the request and falls the next;
  // the write lands at the edge where ack rises
  always_comb begin
    bus_state_next = bus_state_reg;
    gate_sync_next = gate_sync_reg;
    ref_level_next = ref_level_reg;
    rdata_next     = rdata_reg;
    case (bus_state_reg)
      csv_pkg::CSV_BUS_IDLE: begin
        if (req) begin
          bus_state_next = csv_pkg::CSV_BUS_ACK;
          rdata_next     = '0;
          case (wb_adr_i)
            `CSV_ADDR_GATE_SYNC: begin
              rdata_next = {24'h0, gate_sync_reg & `CSV_GS_WMASK}; // [R6] [R7]
              if (wb_we_i && lane_on) begin
                gate_sync_next = wb_dat_i[7:0] & `CSV_GS_WMASK; // [R6] [R7]
              end
            end
            `CSV_ADDR_REF_LEVEL: begin
              rdata_next = {24'h0, ref_level_reg & `CSV_RL_WMASK}; // [R14]
              // no dependence on comparator modes, writes accepted whenever byte lane 0 is selected
              if (wb_we_i && lane_on) begin
                ref_level_next = wb_dat_i[7:0] & `CSV_RL_WMASK; // [R9] [R14]
              end
            end
            default: begin
              rdata_next = '0;
            end
          endcase
        end
      end
      csv_pkg::CSV_BUS_ACK: begin
        bus_state_next = csv_pkg::CSV_BUS_IDLE;
      end
      default: begin
        bus_state_next = csv_pkg::CSV_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state_reg <= csv_pkg::CSV_BUS_IDLE;
      gate_sync_reg <= `CSV_GS_RESET; // [R15]
      ref_level_reg <= `CSV_RL_RESET; // [R15]
      rdata_reg     <= '0;
    end else begin
      bus_state_reg <= bus_state_next;
      gate_sync_reg <= gate_sync_next;
      ref_level_reg <= ref_level_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign wb_ack_o = (bus_state_reg == csv_pkg::CSV_BUS_ACK);
  assign wb_dat_o = rdata_reg;

  // ****************************************
  // comparator path to the timer
  // ****************************************
  csv_latch_if lif ();

  csv_in_sync u_sync_raw (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (timer_clk_src_i),
    .level_o (lif.raw_clk_lvl)
  );

  csv_in_sync u_sync_presc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (timer_presc_clk_i),
    .level_o (lif.presc_clk_lvl)
  );

  csv_in_sync u_sync_cmp (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (second_comparator_i),
    .level_o (lif.cmp_lvl)
  );

  assign lif.sync_en    = gate_sync_reg[`CSV_GS_SYNC_BIT];
  assign lif.presc_used = timer_presc_used_i;

  csv_cmp_latch u_latch (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .lif     (lif.latch)
  );

  // the timer counts on rising edges, the latch moves on falling ones [R3]
  assign comparator_to_timer_o = lif.sync_en ? lif.cmp_latched : second_comparator_i; // [R1] [R4]
  // the timer itself decides whether the gate matters (running, gating on) [R16]
  assign timer_gate_o = gate_sync_reg[`CSV_GS_SEL_BIT] ? external_gate_pin_i : comparator_to_timer_o; // [R5]
  assign sync_to_timer_enable_o = gate_sync_reg[`CSV_GS_SYNC_BIT];
  assign gate_source_select_o   = gate_sync_reg[`CSV_GS_SEL_BIT];

  // ****************************************
  // reference cell controls
  // ****************************************
  assign ref_enable_o          = ref_level_reg[`CSV_RL_EN_BIT]; // [R8] [R17]
  assign ref_range_select_o    = ref_level_reg[`CSV_RL_RANGE_BIT]; // [R10] [R17]
  assign ref_level_code_o      = ref_level_reg[`CSV_RL_LVL_MSB:`CSV_RL_LVL_LSB]; // [R11] [R17]
  assign internal_ref_output_o = csv_ref_96ths(ref_enable_o, ref_range_select_o, ref_level_code_o); // [R12]

endmodule : comparator_sync_vref_ctrl

// >>> csv_timer_model.sv
// behavioural gated timer: raw and prescaled timer clocks plus a gated counter
`timescale 1ns/100ps

module csv_timer_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control from the bench
  input  wire logic       run_i,
  input  wire logic       presc_run_i,
  input  wire logic       presc_used_i,
  input  wire logic       gate_i,
  // timer side
  output logic            raw_clk_o,
  output logic            presc_clk_o,
  output logic [7:0]      count_o
);
  logic [1:0] div_reg;
  logic       tick_clk;

  assign tick_clk = presc_used_i ? presc_clk_o : raw_clk_o;

  // clocks stand high between bursts, so every burst opens with a falling edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg     <= 2'h0;
      raw_clk_o   <= 1'b1;
      presc_clk_o <= 1'b1;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3 && (run_i || !raw_clk_o || !presc_clk_o)) begin
        raw_clk_o <= !raw_clk_o;
        if (!raw_clk_o && (presc_run_i || !presc_clk_o)) presc_clk_o <= !presc_clk_o;
      end
    end
  end

  // counts on the rising edge only, and only while the gate is open
  always_ff @(posedge tick_clk or negedge rst_n_i) begin
    if (!rst_n_i) count_o <= 8'h00;
    else if (gate_i) count_o <= count_o + 8'h01;
  end
endmodule : csv_timer_model

// >>> comparator_sync_vref_ctrl_chk.sv
// concurrent checks on the comparator sync and reference register bank
`timescale 1ns/100ps

module csv_ctrl_chk (
  // clock, reset and register bus
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // timer and reference side
  input wire logic        timer_clk_src_i,
  input wire logic        timer_presc_used_i,
  input wire logic        second_comparator_i,
  input wire logic        external_gate_pin_i,
  input wire logic        comparator_to_timer_o,
  input wire logic        timer_gate_o,
  input wire logic        sync_to_timer_enable_o,
  input wire logic        gate_source_select_o,
  input wire logic        ref_enable_o,
  input wire logic        ref_range_select_o,
  input wire logic [3:0]  ref_level_code_o,
  input wire logic [6:0]  internal_ref_output_o
);
  // ********
  // assertions
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ref_wr;
    s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4);
  endsequence

  a_ack_single_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  a_ref_write_update: assert property (s_ref_wr |=>
    {ref_enable_o, 1'b0, ref_range_select_o, 1'b0, ref_level_code_o} == ($past(wb_dat_i[7:0]) & 8'hAF))
    else $error("reference fields not updated");
  a_gate_readback: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 4'h0
    |-> wb_dat_o == {30'h0, gate_source_select_o, sync_to_timer_enable_o}) else $error("gate readback wrong");
  a_gate_route: assert property (timer_gate_o ==
    (gate_source_select_o ? external_gate_pin_i : comparator_to_timer_o)) else $error("gate route wrong");
  a_async_pass: assert property (!sync_to_timer_enable_o |->
    comparator_to_timer_o == second_comparator_i) else $error("comparator not passed through");
  a_ref_off_ground: assert property (!ref_enable_o |-> internal_ref_output_o == 7'h00)
    else $error("reference not grounded");
  a_ref_low_range: assert property (ref_enable_o && ref_range_select_o |->
    internal_ref_output_o == {1'b0, ref_level_code_o, 2'h0}) else $error("low range level wrong");
  a_ref_high_range: assert property (ref_enable_o && !ref_range_select_o |->
    internal_ref_output_o == 7'h18 + 7'(ref_level_code_o) * 7'h03) else $error("high range level wrong");
  a_sync_holds: assert property ((sync_to_timer_enable_o && !timer_presc_used_i && timer_clk_src_i)[*8]
    |-> $stable(comparator_to_timer_o)) else $error("latched value moved without a falling edge");
endmodule : csv_ctrl_chk

bind comparator_sync_vref_ctrl csv_ctrl_chk csv_ctrl_chk_i (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_clk_src_i, .timer_presc_used_i,
  .second_comparator_i, .external_gate_pin_i, .comparator_to_timer_o, .timer_gate_o, .sync_to_timer_enable_o,
  .gate_source_select_o, .ref_enable_o, .ref_range_select_o, .ref_level_code_o, .internal_ref_output_o);

// >>> comparator_sync_vref_ctrl_test.sv
// self-checking bench for the comparator sync and reference register bank
`timescale 1ns/100ps

module comparator_sync_vref_ctrl_test;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0, ref_level_code_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        timer_presc_used_i = 1'b0, second_comparator_i = 1'b0, external_gate_pin_i = 1'b0;
  logic        run = 1'b0, prun = 1'b0, wb_ack_o, timer_clk_src_i, timer_presc_clk_i, comparator_to_timer_o;
  logic        timer_gate_o, sync_to_timer_enable_o, gate_source_select_o, ref_enable_o, ref_range_select_o;
  logic [6:0]  internal_ref_output_o;
  logic [7:0]  g, v, tcount, t0;
  int          err_total = 0, n_checks = 0;

  comparator_sync_vref_ctrl comparator_sync_vref_ctrl_i (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_clk_src_i, .timer_presc_clk_i,
    .timer_presc_used_i, .second_comparator_i, .external_gate_pin_i, .comparator_to_timer_o, .timer_gate_o,
    .sync_to_timer_enable_o, .gate_source_select_o, .ref_enable_o, .ref_range_select_o, .ref_level_code_o,
    .internal_ref_output_o);
  csv_timer_model csv_timer_model_i (.clk_i, .rst_n_i, .run_i(run), .presc_run_i(prun),
    .presc_used_i(timer_presc_used_i), .gate_i(timer_gate_o), .raw_clk_o(timer_clk_src_i),
    .presc_clk_o(timer_presc_clk_i), .count_o(tcount));

  // ********
  // helpers
  // ********
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one classic cycle; no fixed latency assumed, the watchdog bounds the wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, s};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : bus

  task automatic burst(input logic p, input int n);
    {run, prun} <= {1'b1, p};
    repeat (n) @(posedge clk_i);
    {run, prun} <= 2'h0;
    repeat (32) @(posedge clk_i);
  endtask : burst

  function automatic logic [6:0] ref_exp(input logic [7:0] r);
    if (!r[7]) return 7'h00;
    return r[5] ? {1'b0, r[3:0], 2'h0} : 7'h18 + 7'(r[3:0]) * 7'h03;
  endfunction : ref_exp

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end

  // ********
  // tests
  // ********
  initial begin
    void'($urandom(32'h3968));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      bus(0, 4'h0, 32'h0, 4'hF, q);
      chk(q, 32'h02);
      bus(0, 4'h4, 32'h0, 4'hF, q);
      chk(q, 32'h00);
      if (k == 0) begin
        // every level code in both ranges, with random enable and unused bits
        for (int i = 0; i < 32; i++) begin
          g = 8'($urandom);
          v = {2'h0, i[4], 1'b0, i[3:0]} | (8'($urandom) & 8'hD0);
          bus(1, 4'h0, {24'($urandom), g}, 4'h1, q);
          bus(1, 4'h4, {24'($urandom), v}, 4'h1, q);
          bus(0, 4'h0, 32'h0, 4'hF, q);
          chk(q, {30'h0, g[1:0]});
          bus(0, 4'h4, 32'h0, 4'hF, q);
          chk(q, {24'h0, v & 8'hAF});
          chk(32'({ref_enable_o, ref_range_select_o, ref_level_code_o}), 32'({v[7], v[5], v[3:0]}));
          chk(32'(internal_ref_output_o), 32'(ref_exp(v)));
        end
        bus(1, 4'h4, 32'h20, 4'h1, q);
        chk(32'(internal_ref_output_o), 32'h0);
        bus(1, 4'h4, 32'hFF, 4'hE, q);
        bus(1, 4'h8, 32'hFF, 4'hF, q);
        bus(0, 4'h8, 32'h0, 4'hF, q);
        chk(q, 32'h0);
        bus(0, 4'h4, 32'h0, 4'hF, q);
        chk(q, 32'h20);
        for (int j = 0; j < 2; j++) begin
          bus(1, 4'h0, {30'h0, j[0], 1'b0}, 4'h1, q);
          for (int i = 0; i < 4; i++) begin
            {external_gate_pin_i, second_comparator_i} <= {i[0], i[1]};
            @(posedge clk_i);
            chk(32'(timer_gate_o), 32'(j[0] ? i[0] : i[1]));
            chk(32'(comparator_to_timer_o), 32'(i[1]));
          end
        end
        bus(1, 4'h0, 32'h1, 4'h1, q);
        t0 = tcount;
        burst(1'b0, 16);
        chk(32'(comparator_to_timer_o), 32'h1);
        // first rise comes before the latch opens the gate, only the second one counts
        chk(32'(tcount), 32'(t0) + 32'h1);
        second_comparator_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        chk(32'(comparator_to_timer_o), 32'h1);
        timer_presc_used_i <= 1'b1;
        burst(1'b0, 24);
        chk(32'(comparator_to_timer_o), 32'h1);
        burst(1'b1, 40);
        chk(32'(comparator_to_timer_o), 32'h0);
        // the latch closes the gate on the prescaled fall, before the next rising count edge
        chk(32'(tcount), 32'(t0) + 32'h1);
        bus(1, 4'h4, 32'hAF, 4'h1, q);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
      end
    end
    wrap_up();
  end
endmodule : comparator_sync_vref_ctrl_test
